// ===== acq_map.vh
`ifndef ACQ_MAP_VH
`define ACQ_MAP_VH
// register word addresses
`define ACQ_REG_CTRL      4'h0
`define ACQ_REG_MODE      4'h1
`define ACQ_REG_COUNT     4'h2
`define ACQ_REG_EXPOSURE  4'h3
`define ACQ_REG_PERIOD    4'h4
`define ACQ_REG_TRGDLY    4'h5
`define ACQ_REG_WINDOW    4'h6
`define ACQ_REG_SPEED     4'h7
`define ACQ_REG_STATUS    4'h8
`define ACQ_REG_DONE      4'h9
// ctrl bits (write 1 pulses)
`define ACQ_CTRL_START    0
`define ACQ_CTRL_ABORT    1
`define ACQ_CTRL_SWTRIG   2
// mode fields
`define ACQ_MODE_ACQ_LO   0
`define ACQ_MODE_ACQ_HI   1
`define ACQ_MODE_TRG_LO   2
`define ACQ_MODE_TRG_HI   3
`define ACQ_MODE_GLOBAL   4
`define ACQ_MODE_SCAN_LO  5
`define ACQ_MODE_SCAN_HI  6
`define ACQ_MODE_ALT      7
`define ACQ_MODE_LIVE     8
// acquisition modes
`define ACQ_AM_SINGLE     2'h0
`define ACQ_AM_SERIES     2'h1
`define ACQ_AM_ACCUM      2'h2
`define ACQ_AM_CONT       2'h3
// trigger sources
`define ACQ_TS_INTERNAL   2'h0
`define ACQ_TS_EXTERNAL   2'h1
`define ACQ_TS_HOST       2'h2
// scan patterns
`define ACQ_SC_CENTRE     2'h0
`define ACQ_SC_SINGLE     2'h1
`define ACQ_SC_DUAL_A     2'h2
`define ACQ_SC_DUAL_B     2'h3
// reset values
`define ACQ_RST_MODE      9'h000
`define ACQ_RST_COUNT     32'h0000_0001
`define ACQ_RST_EXPOSURE  32'h0000_0001
`define ACQ_RST_WINDOW    16'h000a
`define ACQ_RST_SPEED     16'h0001
// row time in sensor clocks
`define ACQ_ROW_CLOCKS    2624
`endif

// ===== acq_row_timer.v
`timescale 1ns/1ns
`default_nettype none
// row tick generator: one pulse every ROW_CLOCKS clk_sys cycles while run is high
module acq_row_timer #(
    parameter ROW_CLOCKS = 2624
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        sys_rst,
    // control
    input  wire        run,
    // tick
    output reg         row_tick
);
    reg [15:0] cnt_q;
    always @(posedge clk_sys) begin
        if (sys_rst || !run) begin
            cnt_q    <= 16'h0000;
            row_tick <= 1'b0;
        end else if (cnt_q == ROW_CLOCKS[15:0] - 16'h0001) begin
            cnt_q    <= 16'h0000;
            row_tick <= 1'b1;
        end else begin
            cnt_q    <= cnt_q + 16'h0001;
            row_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== acq_sequencer.v
`timescale 1ns/1ns
`default_nettype none
`include "acq_map.vh"
module acq_sequencer #(
    parameter ROW_CLOCKS  = `ACQ_ROW_CLOCKS,
    parameter READ_ROWS   = 1080
) (
    // clock and reset
    input  wire        clk_sys,
    input  wire        sys_rst,
    // avalon-mm slave
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    // external trigger pin
    input  wire        ext_trigger,
    // sensor side
    input  wire        sensor_readout_done,
    output reg         sensor_expose,
    output reg         sensor_readout,
    output reg         sensor_reference,
    output reg  [1:0]  scan_pattern,
    output reg         scan_upward,
    // output link
    input  wire        link_frame_sent,
    output reg         frame_send,
    // status
    output reg         trigger_ready,
    output reg         acq_running
);
    localparam ST_IDLE   = 3'h0;
    localparam ST_WAIT   = 3'h1;
    localparam ST_DELAY  = 3'h2;
    localparam ST_REF    = 3'h3;
    localparam ST_EXPOSE = 3'h4;
    localparam ST_READ   = 3'h5;
    localparam ST_SEND   = 3'h6;
    localparam ST_PACE   = 3'h7;

    reg [2:0]  state_q;
    reg [8:0]  mode_q;
    reg [31:0] count_q;
    reg [31:0] exposure_q;
    reg [31:0] exp_live_q;
    reg [31:0] period_q;
    reg [31:0] trgdly_q;
    reg [15:0] window_q;
    reg [15:0] speed_q;
    reg [31:0] frames_q;
    reg [31:0] rows_q;
    reg [31:0] pace_q;
    reg        start_q;
    reg        abort_q;
    reg        swtrig_q;
    reg        sweep_flip_q;
    reg [2:0]  ext_sync_q;
    reg        ext_level_q;
    reg        ext_edge_q;

    wire [1:0] acq_mode   = mode_q[`ACQ_MODE_ACQ_HI:`ACQ_MODE_ACQ_LO];
    wire [1:0] trig_src   = mode_q[`ACQ_MODE_TRG_HI:`ACQ_MODE_TRG_LO];
    wire       global_sh  = mode_q[`ACQ_MODE_GLOBAL];
    wire       alternating_sweep_direction = mode_q[`ACQ_MODE_ALT];
    wire       live_mode  = mode_q[`ACQ_MODE_LIVE];
    wire       row_tick;

    function [31:0] rd_mux;
        input [3:0] a;
        begin
            case (a)
                `ACQ_REG_MODE:     rd_mux = {23'h000000, mode_q};
                `ACQ_REG_COUNT:    rd_mux = count_q;
                `ACQ_REG_EXPOSURE: rd_mux = exposure_q;
                `ACQ_REG_PERIOD:   rd_mux = period_q;
                `ACQ_REG_TRGDLY:   rd_mux = trgdly_q;
                `ACQ_REG_WINDOW:   rd_mux = {16'h0000, window_q};
                `ACQ_REG_SPEED:    rd_mux = {16'h0000, speed_q};
                `ACQ_REG_STATUS:   rd_mux = {26'h0000000, sweep_flip_q, trigger_ready,
                                             acq_running, state_q};
                `ACQ_REG_DONE:     rd_mux = frames_q;
                default:           rd_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    // avalon slave: one wait cycle, answer on second cycle of request
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            mode_q          <= `ACQ_RST_MODE;
            count_q         <= `ACQ_RST_COUNT;
            exposure_q      <= `ACQ_RST_EXPOSURE;
            period_q        <= 32'h0000_0000;
            trgdly_q        <= 32'h0000_0000;
            window_q        <= `ACQ_RST_WINDOW;
            speed_q         <= `ACQ_RST_SPEED;
            start_q         <= 1'b0;
            abort_q         <= 1'b0;
            swtrig_q        <= 1'b0;
        end else begin
            start_q  <= 1'b0;
            abort_q  <= 1'b0;
            swtrig_q <= 1'b0;
            if ((avs_read || avs_write) && avs_waitrequest) begin
                avs_waitrequest <= 1'b0;
                avs_readdata    <= rd_mux(avs_address);
                if (avs_write) begin
                    case (avs_address)
                        `ACQ_REG_CTRL: begin
                            start_q  <= avs_writedata[`ACQ_CTRL_START];
                            abort_q  <= avs_writedata[`ACQ_CTRL_ABORT];
                            swtrig_q <= avs_writedata[`ACQ_CTRL_SWTRIG];
                        end
                        // setup fields only change while idle, except exposure, which is written at any time
                        `ACQ_REG_MODE:     if (!acq_running) mode_q <= avs_writedata[8:0];
                        `ACQ_REG_COUNT:    if (!acq_running) count_q <= avs_writedata;
                        `ACQ_REG_EXPOSURE: exposure_q <= avs_writedata;
                        `ACQ_REG_PERIOD:   if (!acq_running) period_q <= avs_writedata;
                        `ACQ_REG_TRGDLY:   if (!acq_running) trgdly_q <= avs_writedata;
                        `ACQ_REG_WINDOW:   if (!acq_running) window_q <= avs_writedata[15:0];
                        `ACQ_REG_SPEED:    if (!acq_running) speed_q <= avs_writedata[15:0];
                        default: ;
                    endcase
                end
            end else begin
                avs_waitrequest <= 1'b1;
            end
        end
    end

    // external trigger: three flops, change counts when last two agree
    always @(posedge clk_sys) begin
        if (sys_rst) begin
            ext_sync_q  <= 3'h0;
            ext_level_q <= 1'b0;
            ext_edge_q  <= 1'b0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], ext_trigger};
            ext_edge_q <= 1'b0;
            if (ext_sync_q[2] == ext_sync_q[1] && ext_sync_q[2] != ext_level_q) begin
                ext_level_q <= ext_sync_q[2];
                ext_edge_q  <= ext_sync_q[2];
            end
        end
    end

    // row phase restarts with each exposure so it lasts whole rows
    wire row_run = acq_running && (state_q != ST_REF);

    acq_row_timer #(
        .ROW_CLOCKS (ROW_CLOCKS)
    ) u_row (
        .clk_sys  (clk_sys),
        .sys_rst  (sys_rst),
        .run      (row_run),
        .row_tick (row_tick)
    );

    // trigger of the selected type; internal fires whenever ready (max rate)
    reg trig_now;
    always @* begin
        case (trig_src)
            `ACQ_TS_INTERNAL: trig_now = 1'b1;
            `ACQ_TS_EXTERNAL: trig_now = ext_edge_q;
            `ACQ_TS_HOST:     trig_now = swtrig_q;
            default:          trig_now = 1'b0;
        endcase
    end

    wire limit_hit = (acq_mode == `ACQ_AM_SINGLE && frames_q != 32'h0) ||
                     (acq_mode == `ACQ_AM_SERIES && frames_q >= count_q);
    wire valid_trig = trigger_ready && trig_now;
    wire long_exp  = exp_live_q > READ_ROWS;

    always @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q          <= ST_IDLE;
            acq_running      <= 1'b0;
            trigger_ready    <= 1'b0;
            frames_q         <= 32'h0000_0000;
            rows_q           <= 32'h0000_0000;
            pace_q           <= 32'h0000_0000;
            exp_live_q       <= `ACQ_RST_EXPOSURE;
            sensor_expose    <= 1'b0;
            sensor_readout   <= 1'b0;
            sensor_reference <= 1'b0;
            scan_pattern     <= `ACQ_SC_CENTRE;
            scan_upward      <= 1'b0;
            sweep_flip_q     <= 1'b0;
            frame_send       <= 1'b0;
        end else if (abort_q) begin
            state_q          <= ST_IDLE;
            acq_running      <= 1'b0;
            trigger_ready    <= 1'b0;
            sensor_expose    <= 1'b0;
            sensor_readout   <= 1'b0;
            sensor_reference <= 1'b0;
            frame_send       <= 1'b0;
        end else begin
            frame_send <= 1'b0;
            case (state_q)
                ST_IDLE: if (start_q) begin
                    frames_q     <= 32'h0000_0000;
                    acq_running  <= 1'b1;
                    sweep_flip_q <= 1'b0;
                    scan_pattern <= mode_q[`ACQ_MODE_SCAN_HI:`ACQ_MODE_SCAN_LO];
                    state_q      <= ST_WAIT;
                    trigger_ready <= 1'b1;
                end
                ST_WAIT: begin
                    if (limit_hit) begin
                        state_q       <= ST_IDLE;
                        acq_running   <= 1'b0;
                        trigger_ready <= 1'b0;
                    end else if (valid_trig) begin
                        trigger_ready <= 1'b0;
                        exp_live_q    <= exposure_q;
                        scan_upward   <= alternating_sweep_direction & sweep_flip_q;
                        rows_q        <= 32'h0000_0000;
                        pace_q        <= 32'h0000_0000;
                        state_q       <= (trig_src == `ACQ_TS_EXTERNAL) ? ST_DELAY : ST_REF;
                    end
                end
                ST_DELAY: begin
                    if (rows_q >= trgdly_q) begin
                        rows_q  <= 32'h0000_0000;
                        state_q <= ST_REF;
                    end else begin
                        rows_q <= rows_q + 32'h1;
                    end
                end
                ST_REF: begin
                    if (global_sh) begin
                        sensor_reference <= 1'b1;
                        if (sensor_readout_done && sensor_reference) begin
                            sensor_reference <= 1'b0;
                            sensor_expose    <= 1'b1;
                            state_q          <= ST_EXPOSE;
                        end
                    end else begin
                        sensor_expose <= 1'b1;
                        state_q       <= ST_EXPOSE;
                    end
                end
                ST_EXPOSE: begin
                    if (row_tick) begin
                        pace_q <= pace_q + 32'h1;
                        if (rows_q + 32'h1 >= exp_live_q) begin
                            sensor_expose  <= 1'b0;
                            sensor_readout <= 1'b1;
                            state_q        <= ST_READ;
                        end else begin
                            rows_q <= rows_q + 32'h1;
                        end
                    end
                end
                ST_READ: if (sensor_readout_done) begin
                    sensor_readout <= 1'b0;
                    frame_send     <= 1'b1;
                    frames_q       <= frames_q + 32'h1;
                    sweep_flip_q   <= ~sweep_flip_q;
                    state_q        <= ST_SEND;
                end
                ST_SEND: if (link_frame_sent || !live_mode) begin
                    state_q <= ST_PACE;
                end
                ST_PACE: begin
                    if (row_tick) begin
                        pace_q <= pace_q + 32'h1;
                    end
                    // period limit counts rows; long exposures only
                    if (trig_src != `ACQ_TS_INTERNAL || period_q == 32'h0 || !long_exp ||
                        pace_q >= period_q) begin
                        state_q       <= ST_WAIT;
                        trigger_ready <= ~limit_hit;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ===== acq_seq_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module acq_seq_monitor (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    // bus
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest,
    // sensor
    input  wire logic        sensor_expose,
    input  wire logic        sensor_readout,
    input  wire logic        sensor_reference,
    input  wire logic [1:0]  scan_pattern,
    input  wire logic        scan_upward,
    // link and status
    input  wire logic        frame_send,
    input  wire logic        trigger_ready,
    input  wire logic        acq_running
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    logic ctl_w;
    assign ctl_w = avs_write && !avs_waitrequest && avs_address == 4'h0;
    a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer late");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    a_data_hold: assert property (!avs_read && !avs_write |=> $stable(avs_readdata))
        else $error("read data moved while idle");
    a_send_pulse: assert property (frame_send |=> !frame_send)
        else $error("frame send not a pulse");
    a_send_cause: assert property (frame_send |-> $past(sensor_readout) || $past(sensor_readout, 2))
        else $error("frame sent without readout");
    a_ready_quiet: assert property (trigger_ready |-> !sensor_expose && !sensor_readout)
        else $error("ready while busy");
    a_idle_quiet: assert property (!acq_running |-> !trigger_ready && !sensor_expose)
        else $error("activity while idle");
    a_no_overlap: assert property (sensor_expose |-> !sensor_readout)
        else $error("expose overlaps readout");
    a_scan_hold: assert property (sensor_readout && $past(sensor_readout) |->
        $stable(scan_upward) && $stable(scan_pattern))
        else $error("scan changed in readout");
    a_abort_idle: assert property (ctl_w && avs_writedata[1] |-> ##[1:2] !acq_running)
        else $error("abort not honoured");
    a_start_run: assert property (ctl_w && avs_writedata[0] && !avs_writedata[1] |->
        ##[1:2] acq_running)
        else $error("start not honoured");
    c_frame: cover property (frame_send);
    c_reference: cover property ($rose(sensor_reference));
    c_abort: cover property (ctl_w && avs_writedata[1] && acq_running);
endmodule
bind acq_sequencer acq_seq_monitor u_mon (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sensor_expose(sensor_expose),
    .sensor_readout(sensor_readout), .sensor_reference(sensor_reference),
    .scan_pattern(scan_pattern), .scan_upward(scan_upward), .frame_send(frame_send),
    .trigger_ready(trigger_ready), .acq_running(acq_running));
`default_nettype wire

// ===== acq_far_model.sv
`timescale 1ns/1ns
`default_nettype none
module acq_far_model (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic sys_rst,
    // pacing choice
    input  wire logic slow,
    // sensor side
    input  wire logic sensor_readout,
    input  wire logic sensor_reference,
    output logic      sensor_readout_done,
    // link side
    input  wire logic frame_send,
    output logic      link_frame_sent
);
    logic [3:0] rd_q;
    logic [3:0] ln_q;
    // answers image and reference reads alike, quick or slow
    always @(posedge clk_sys) begin
        sensor_readout_done <= 1'b0;
        link_frame_sent <= 1'b0;
        rd_q <= 4'h0;
        if (!sys_rst && (sensor_readout || sensor_reference)) begin
            rd_q <= rd_q + 4'h1;
            if (rd_q == (slow ? 4'h9 : 4'h3)) begin
                sensor_readout_done <= 1'b1;
                rd_q <= 4'h0;
            end
        end
        if (sys_rst)
            ln_q <= 4'h0;
        else if (frame_send)
            ln_q <= slow ? 4'hc : 4'h2;
        else if (ln_q != 4'h0) begin
            ln_q <= ln_q - 4'h1;
            link_frame_sent <= (ln_q == 4'h1);
        end
    end
endmodule
`default_nettype wire

// ===== tb_acquisition_sequencer.sv
`timescale 1ns/1ns
`default_nettype none
module tb_acquisition_sequencer;
    logic        clk_sys, sys_rst, avs_read, avs_write, ext_trigger, slow, avs_waitrequest;
    logic [3:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd, mode;
    logic        done_w, sent_w, expose, readout, reference, upward, send, ready, running;
    logic [1:0]  pattern;
    logic        ref_q, live_q, pend;
    logic        ups[$];
    integer      fail_count, cmp_count, seed, frames, refs, len, last_len, cyc, exp_rows, p, n;
    logic [3:0]  ra[6] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h7, 4'hf};
    logic [31:0] rv[6] = '{32'h0, 32'h1, 32'h1, 32'ha, 32'h1, 32'h0};
    acq_sequencer #(.ROW_CLOCKS(4), .READ_ROWS(2)) dut_u (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .ext_trigger(ext_trigger),
        .sensor_readout_done(done_w), .sensor_expose(expose), .sensor_readout(readout),
        .sensor_reference(reference), .scan_pattern(pattern), .scan_upward(upward),
        .link_frame_sent(sent_w), .frame_send(send), .trigger_ready(ready),
        .acq_running(running));
    acq_far_model far_u (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .slow(slow), .sensor_readout(readout),
        .sensor_reference(reference), .sensor_readout_done(done_w), .frame_send(send),
        .link_frame_sent(sent_w));
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            fail_count = fail_count + 1;
        end
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // frame log, exposure length and the live hold-off watch
    always @(posedge clk_sys) begin
        if (send === 1'b1) begin
            frames = frames + 1;
            ups.push_back(upward);
            pend = live_q;
        end
        if (sent_w === 1'b1)
            pend = 1'b0;
        if (pend && ready === 1'b1)
            chk("live_hold", 32'(pend), 32'h0);
        if (reference === 1'b1 && ref_q !== 1'b1)
            refs = refs + 1;
        ref_q = reference;
        if (expose === 1'b1)
            len = len + 1;
        else if (len != 0) begin
            last_len = len;
            len = 0;
        end
        cyc = cyc + 1;
        if (cyc > 60000) begin
            fail_count = fail_count + 1;
            report_and_stop;
        end
    end
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    // waits for the frame, then for ready again, or for the run to end
    task automatic wait_next(input integer f0);
        n = 0;
        while ((frames == f0 || ready !== 1'b1) && running === 1'b1 && n < 600) begin
            @(posedge clk_sys);
            n = n + 1;
        end
    endtask
    task automatic host_trig;
        integer f0;
        f0 = frames;
        bus(1'b1, 4'h0, 32'h4);
        wait_next(f0);
    endtask
    task automatic acq(input logic [31:0] m, input logic [31:0] c, input integer k);
        bus(1'b1, 4'h1, m);
        bus(1'b1, 4'h2, c);
        frames = 0;
        refs = 0;
        ups.delete();
        bus(1'b1, 4'h0, 32'h1);
        repeat (k) host_trig;
    endtask
    initial begin
        seed = 93493;
        {fail_count, cmp_count, frames, refs, len, last_len, cyc} = '0;
        {ref_q, live_q, pend, slow, ext_trigger, avs_read, avs_write} = '0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (p = 0; p < 6; p++) begin
            bus(1'b0, ra[p], 32'h0);
            chk("reset_value", rd, rv[p]);
        end
        bus(1'b1, 4'h6, 32'h14);
        bus(1'b1, 4'h7, 32'h29);
        bus(1'b1, 4'hf, 32'h5);
        bus(1'b0, 4'h6, 32'h0);
        chk("window", rd, 32'h14);
        bus(1'b0, 4'h7, 32'h0);
        chk("speed", rd, 32'h29);
        bus(1'b0, 4'hf, 32'h0);
        chk("unmapped", rd, 32'h0);
        acq(32'h009, 32'h3, 5);
        chk("series_frames", frames, 3);
        bus(1'b0, 4'h9, 32'h0);
        chk("series_done", rd, 32'h3);
        acq(32'h018, 32'h1, 3);
        chk("single_frames", frames, 1);
        chk("reference_reads", refs, 1);
        for (p = 0; p < 4; p++) begin
            slow = $random(seed);
            exp_rows = 1 + $unsigned($random(seed)) % 3;
            mode = 32'h08a | (p << 5) | (p & 1);
            bus(1'b1, 4'h3, exp_rows);
            acq(mode, 32'h1, 1);
            bus(1'b1, 4'h3, exp_rows + 1);
            bus(1'b1, 4'h1, 32'h0);
            repeat (2) host_trig;
            chk("cont_frames", frames, 3);
            chk("pattern", pattern, p);
            chk("sweep_a", ups[0] ^ ups[1], 1);
            chk("sweep_b", ups[1] ^ ups[2], 1);
            chk("exposure", (last_len + 2) / 4, exp_rows + 1);
            bus(1'b0, 4'h1, 32'h0);
            chk("mode_locked", rd, mode);
            bus(1'b1, 4'h0, 32'h2);
            host_trig;
            chk("abort_frames", frames, 3);
            chk("abort_idle", running, 0);
        end
        slow = 1'b1;
        live_q = 1'b1;
        acq(32'h10b, 32'h1, 3);
        live_q = 1'b0;
        chk("live_frames", frames, 3);
        bus(1'b1, 4'h0, 32'h2);
        bus(1'b1, 4'h4, 32'h0);
        acq(32'h003, 32'h1, 0);
        repeat (300) @(posedge clk_sys);
        bus(1'b1, 4'h0, 32'h2);
        bus(1'b0, 4'h9, 32'h0);
        chk("free_done", rd, frames);
        chk("free_rate", frames > 2, 1);
        bus(1'b1, 4'h4, 32'd30);
        bus(1'b1, 4'h3, 32'h3);
        acq(32'h003, 32'h1, 0);
        repeat (400) @(posedge clk_sys);
        bus(1'b1, 4'h0, 32'h2);
        chk("rate_limit", frames >= 2 && frames <= 4, 1);
        bus(1'b1, 4'h5, 32'd20);
        acq(32'h005, 32'h2, 0);
        repeat (2) begin
            ext_trigger <= 1'b1;
            n = 0;
            while (expose !== 1'b1 && n < 300) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            chk("ext_delay", n >= 20, 1);
            ext_trigger <= 1'b0;
            wait_next(frames);
        end
        chk("ext_frames", frames, 2);
        report_and_stop;
    end
endmodule
`default_nettype wire
